// ---- rtl/cat_params.svh ----
// constants of the counter array core: register map, field positions,
// reset values and timing figures; assumes a 20 MHz system clock.
`ifndef CAT_PARAMS_SVH
`define CAT_PARAMS_SVH

// byte offsets on the register bus
`define CAT_OFF_MODE 8'h00
`define CAT_OFF_CNTLO 8'h04
`define CAT_OFF_CNTHI 8'h08
`define CAT_OFF_FLAGS 8'h0c
`define CAT_OFF_MASK 8'h10
`define CAT_OFF_CH0 8'h14
`define CAT_CH_STRIDE 8'h04

// mode register fields
`define CAT_MODE_TB_LO 0
`define CAT_MODE_IDLE 3
`define CAT_MODE_CLEN_LO 4
`define CAT_MODE_WD 6
`define CAT_MODE_RESET 7'h40

// flag / mask layout
`define CAT_F_OVF 0
`define CAT_F_PART 1
`define CAT_F_CH0 2

// channel config bits above the 16-bit compare value
`define CAT_CH_MATCH 16
`define CAT_CH_TOGGLE 17
`define CAT_CH_IOEN 18

// timebase codes
`define CAT_TB_DIV12 3'h0
`define CAT_TB_DIV4 3'h1
`define CAT_TB_T0 3'h2
`define CAT_TB_EXTCNT 3'h3
`define CAT_TB_SYS 3'h4
`define CAT_TB_EXTOSC 3'h5
`define CAT_TB_RTC 3'h6

`define CAT_DIV12_LAST 4'hb
`define CAT_DIV4_LAST 2'h3
`define CAT_CNT_ALL1 16'hffff
`define CAT_PART_BASE 8
// low-bits mask of the longest intermediate period, eleven bits
`define CAT_PART_MASK 12'h7ff

`endif

// ---- rtl/cat_pkg.sv ----
// types shared by the counter array core.
// assumes cat_params.svh for the numeric constants.
package cat_pkg;

  typedef logic [2:0] cat_tb_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] snap;
    logic [6:0] mode;
    logic [4:0] flags;
    logic [4:0] mask;
    logic [2:0][15:0] cmp;
    logic [2:0][2:0] chCfg;
    logic [2:0] ioLvl;
    logic [3:0] div12;
    logic [1:0] div4;
    logic extCntPrev;
    logic eo1;
    logic eo2;
    logic eo3;
    logic rt1;
    logic rt2;
    logic rt3;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wdExpire;
  } cat_state_t;

endpackage

// ---- rtl/cat_counter_array.sv ----
// counter array core: 16-bit counter, timebase select, overflow flags,
// three compare channels and one maskable interrupt, on an APB slave.
// assumes all inputs synchronous to sys_clk except the two oscillator/8
// levels, which are synchronised here.
//
// Implementation choices: the APB register port and the register addresses.
`include "cat_params.svh"

module cat_counter_array
  import cat_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idleMode,
  input wire logic timer0Overflow,
  input wire logic externalCountInput,
  input wire logic extOscDiv8,
  input wire logic rtcOscDiv8,
  output logic arrayIrq,
  output logic [2:0] channelIoOut,
  output logic [2:0] channelIoOe,
  output logic watchdogExpire
);

  cat_state_t st;
  cat_state_t nx;

  function automatic logic partialWrap(input logic [15:0] c,
                                       input logic [1:0] len);
    logic [11:0] m;
    // shorter periods shift the eleven-bit mask down
    m = `CAT_PART_MASK >> (2'h3 - len);
    return (c[11:0] & m) == m;
  endfunction

  function automatic logic hitAddr(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // helper terms
  logic setup;
  logic done;
  logic wrDone;
  logic tick;
  logic wdMode;
  logic [2:0] tbSel;
  logic [15:0] cntInc;
  logic [4:0] setFlags;
  logic [4:0] clrFlags;
  logic [2:0] chMatch;
  logic mapped;
  logic [31:0] rdVal;

  assign setup = psel && !penable;
  assign done = psel && penable && st.pready;
  assign wrDone = done && pwrite;
  assign wdMode = st.mode[`CAT_MODE_WD];
  assign tbSel = st.mode[`CAT_MODE_TB_LO +: 3];
  assign cntInc = st.cnt + 16'h0001;

  // count pulse selection and idle gating
  always_comb
  begin
    logic pulse;
    pulse = 1'b0;
    unique case (tbSel)
      `CAT_TB_DIV12: pulse = st.div12 == `CAT_DIV12_LAST;
      `CAT_TB_DIV4: pulse = st.div4 == `CAT_DIV4_LAST;
      `CAT_TB_T0: pulse = timer0Overflow;
      `CAT_TB_EXTCNT: pulse = st.extCntPrev && !externalCountInput;
      `CAT_TB_SYS: pulse = 1'b1;
      `CAT_TB_EXTOSC: pulse = st.eo2 && !st.eo3;
      `CAT_TB_RTC: pulse = st.rt2 && !st.rt3;
      default: pulse = 1'b0;
    endcase
    // idle stops counting only when suspend is requested
    tick = pulse && !(st.mode[`CAT_MODE_IDLE] && idleMode);
  end

  // channel matches against the value the counter moves to
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      chMatch[i] = tick && (cntInc == st.cmp[i]) &&
                   (st.chCfg[i][`CAT_CH_MATCH - 16] ||
                    (i == 2 && wdMode));
    end
  end

  // read mux, evaluated in the setup cycle
  always_comb
  begin
    rdVal = 32'h0000_0000;
    mapped = 1'b1;
    if (hitAddr(paddr, `CAT_OFF_MODE))
      rdVal = {25'h0, st.mode};
    else if (hitAddr(paddr, `CAT_OFF_CNTLO))
      rdVal = {24'h0, st.cnt[7:0]};
    else if (hitAddr(paddr, `CAT_OFF_CNTHI))
      rdVal = {24'h0, st.snap};
    else if (hitAddr(paddr, `CAT_OFF_FLAGS))
      rdVal = {27'h0, st.flags};
    else if (hitAddr(paddr, `CAT_OFF_MASK))
      rdVal = {27'h0, st.mask};
    else
    begin
      mapped = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        if (hitAddr(paddr, 8'(`CAT_OFF_CH0 + i * `CAT_CH_STRIDE)))
        begin
          mapped = 1'b1;
          rdVal = {13'h0, st.chCfg[i], st.cmp[i]};
        end
      end
    end
  end

  // next state
  always_comb
  begin
    nx = st;

    // synchronisers and edge history
    nx.eo1 = extOscDiv8;
    nx.eo2 = st.eo1;
    nx.eo3 = st.eo2;
    nx.rt1 = rtcOscDiv8;
    nx.rt2 = st.rt1;
    nx.rt3 = st.rt2;
    nx.extCntPrev = externalCountInput;

    // free-running prescalers
    nx.div12 = (st.div12 == `CAT_DIV12_LAST) ? 4'h0 : st.div12 + 4'h1;
    nx.div4 = st.div4 + 2'h1;

    // counter
    if (tick)
      nx.cnt = cntInc;

    // bus answer: one wait-free access phase, data from the setup cycle
    nx.pready = setup;
    if (setup)
    begin
      nx.prdata = pwrite ? 32'h0000_0000 : rdVal;
      nx.pslverr = !mapped;
      // latch with the same sample as the low byte, so they pair up
      if (!pwrite && hitAddr(paddr, `CAT_OFF_CNTLO))
        nx.snap = st.cnt[15:8];
    end

    // event flags: hardware set wins over a software clear
    setFlags = 5'h00;
    setFlags[`CAT_F_OVF] = tick && st.cnt == `CAT_CNT_ALL1;
    setFlags[`CAT_F_PART] =
      tick && partialWrap(st.cnt, st.mode[`CAT_MODE_CLEN_LO +: 2]);
    setFlags[`CAT_F_CH0 +: 3] = chMatch;
    clrFlags = 5'h00;
    if (wrDone && hitAddr(paddr, `CAT_OFF_FLAGS))
      clrFlags = pwdata[4:0];
    // only a software write clears; no acknowledge path exists
    nx.flags = (st.flags & ~clrFlags) | setFlags;

    // channel outputs toggle on match when enabled
    for (int i = 0; i < 3; i++)
    begin
      if (chMatch[i] && st.chCfg[i][`CAT_CH_TOGGLE - 16])
        nx.ioLvl[i] = !st.ioLvl[i];
    end

    nx.wdExpire = chMatch[2] && wdMode;

    // register writes, taken at the completing edge
    if (wrDone)
    begin
      if (hitAddr(paddr, `CAT_OFF_MODE))
      begin
        // watchdog on: only the watchdog bit itself may change
        if (!wdMode)
          nx.mode = pwdata[6:0];
        else
          nx.mode[`CAT_MODE_WD] = pwdata[`CAT_MODE_WD];
      end
      if (hitAddr(paddr, `CAT_OFF_CNTLO))
        nx.cnt[7:0] = pwdata[7:0];
      if (hitAddr(paddr, `CAT_OFF_CNTHI))
        nx.cnt[15:8] = pwdata[7:0];
      if (hitAddr(paddr, `CAT_OFF_MASK))
        nx.mask = pwdata[4:0];
      for (int i = 0; i < 3; i++)
      begin
        if (hitAddr(paddr, 8'(`CAT_OFF_CH0 + i * `CAT_CH_STRIDE)) &&
            !(i == 2 && wdMode))
        begin
          nx.cmp[i] = pwdata[15:0];
          nx.chCfg[i] = pwdata[18:16];
        end
      end
    end

    // one request from all enabled flags
    nx.irq = |(nx.flags & nx.mask);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.mode <= `CAT_MODE_RESET;
    end
    else
    begin
      st <= nx;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign arrayIrq = st.irq;
  assign channelIoOut = st.ioLvl;
  assign channelIoOe = {st.chCfg[2][`CAT_CH_IOEN - 16],
                        st.chCfg[1][`CAT_CH_IOEN - 16],
                        st.chCfg[0][`CAT_CH_IOEN - 16]};
  assign watchdogExpire = st.wdExpire;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic cntWrite;
  assign cntWrite = wrDone && (hitAddr(paddr, `CAT_OFF_CNTLO) ||
                               hitAddr(paddr, `CAT_OFF_CNTHI));

  // plain flag too, so boolean terms can use it where a sequence cannot
  logic rdLowNow;
  assign rdLowNow = setup && !pwrite && hitAddr(paddr, `CAT_OFF_CNTLO);

  sequence rdLowSetup;
    rdLowNow;
  endsequence

  sequence rdHighDone;
    done && !pwrite && hitAddr(paddr, `CAT_OFF_CNTHI);
  endsequence

  chk_snap_latch: assert property (
    rdLowSetup |=> st.snap == $past(st.cnt[15:8]) && st.pready)
    else $error("snapshot not latched on low byte read");

  chk_snap_return: assert property (
    rdHighDone |-> prdata == {24'h0, st.snap})
    else $error("high byte read did not return snapshot");

  chk_read_nodisturb: assert property (
    (rdLowSetup and (tick && !cntWrite))
    |=> st.cnt == $past(st.cnt) + 16'h1)
    else $error("counter disturbed by a read");

  chk_count_step: assert property (
    tick && !cntWrite |=> st.cnt == $past(cntInc))
    else $error("counter did not advance on a pulse");

  chk_sys_tb: assert property (
    tbSel == `CAT_TB_SYS && !(st.mode[`CAT_MODE_IDLE] && idleMode) &&
    !cntWrite |=> st.cnt == $past(st.cnt) + 16'h1)
    else $error("system clock timebase missed a count");

  chk_div12_rate: assert property (
    tbSel == `CAT_TB_DIV12 && tick |=> !tick [*8] ##1 !tick [*3])
    else $error("divide by twelve pulses too close");

  chk_reserved_hold: assert property (
    tbSel == 3'h7 && !cntWrite |=> $stable(st.cnt))
    else $error("reserved timebase moved the counter");

  chk_ovf_set: assert property (
    tick && st.cnt == `CAT_CNT_ALL1 |=> st.flags[`CAT_F_OVF] &&
    (st.cnt == 16'h0000 || $past(cntWrite)))
    else $error("wrap did not set overflow flag");

  chk_ovf_sticky: assert property (
    st.flags[`CAT_F_OVF] && !(wrDone && hitAddr(paddr, `CAT_OFF_FLAGS))
    |=> st.flags[`CAT_F_OVF])
    else $error("overflow flag dropped without a clear");

  chk_part_set: assert property (
    tick && partialWrap(st.cnt, st.mode[`CAT_MODE_CLEN_LO +: 2])
    |=> st.flags[`CAT_F_PART])
    else $error("intermediate overflow not flagged");

  chk_irq_gate: assert property (
    ##1 arrayIrq == |(st.flags & st.mask))
    else $error("interrupt does not follow enabled flags");

  chk_wd_lock: assert property (
    wdMode && wrDone && hitAddr(paddr, `CAT_OFF_MODE)
    |=> st.mode[5:0] == $past(st.mode[5:0]))
    else $error("mode changed while watchdog on");

  // each source must step the counter one edge after its pulse
  logic idleHold;
  assign idleHold = st.mode[`CAT_MODE_IDLE] && idleMode;

  sequence stepped;
    st.cnt == $past(cntInc);
  endsequence

  chk_t0_count: assert property (
    tbSel == `CAT_TB_T0 && timer0Overflow && !idleHold && !cntWrite
    |=> stepped)
    else $error("timer0 overflow pulse not counted");

  chk_extcnt_fall: assert property (
    tbSel == `CAT_TB_EXTCNT && st.extCntPrev && !externalCountInput &&
    !idleHold && !cntWrite |=> stepped)
    else $error("falling count input edge not counted");

  chk_div4_rate: assert property (
    tbSel == `CAT_TB_DIV4 && tick |=> !tick [*3])
    else $error("divide by four pulses too close");

  // oscillator levels reach the counter only through two flops
  chk_osc_sync: assert property (
    tbSel == `CAT_TB_EXTOSC && tick
    |-> $past(extOscDiv8, 2) && !$past(extOscDiv8, 3))
    else $error("oscillator count not from a synchronised edge");

  chk_rtc_sync: assert property (
    tbSel == `CAT_TB_RTC && tick
    |-> $past(rtcOscDiv8, 2) && !$past(rtcOscDiv8, 3))
    else $error("rtc count not from a synchronised edge");

  chk_idle_stop: assert property (
    idleHold && !cntWrite |=> $stable(st.cnt))
    else $error("counter moved while suspended in idle");

  // set beats a same-cycle clear, so every raised flag must be seen
  chk_flag_set: assert property (
    setFlags != 5'h00
    |=> (st.flags & $past(setFlags)) == $past(setFlags))
    else $error("event flag lost on its trigger");

  // a mask write in the same cycle may legally drop the request
  chk_irq_raise: assert property (
    |(setFlags & st.mask) && !(wrDone && hitAddr(paddr, `CAT_OFF_MASK))
    |=> arrayIrq)
    else $error("enabled event raised no interrupt");

  chk_ch_toggle: assert property (
    chMatch[0] && st.chCfg[0][`CAT_CH_TOGGLE - 16]
    |=> channelIoOut[0] != $past(channelIoOut[0]))
    else $error("channel line did not toggle on match");

  chk_wd_pulse: assert property (
    chMatch[2] && wdMode |=> watchdogExpire)
    else $error("watchdog match gave no expiry pulse");

  chk_wd_quiet: assert property (
    !(chMatch[2] && wdMode) |=> !watchdogExpire)
    else $error("expiry pulse without a watchdog match");

  chk_wd_chlock: assert property (
    wdMode && wrDone &&
    hitAddr(paddr, 8'(`CAT_OFF_CH0 + 2 * `CAT_CH_STRIDE))
    |=> $stable(st.cmp[2]) && $stable(st.chCfg[2]))
    else $error("watchdog channel changed while locked");

endmodule // cat_counter_array

// ---- sim/cat_counter_array_bench.sv ----
// testbench of the counter array core: APB tasks, count sources, flags, irq.
// assumes a one-cycle APB answer and the register map of cat_params.svh.
`include "cat_params.svh"

module cat_counter_array_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] aMode = `CAT_OFF_MODE;
  localparam logic [7:0] aLo = `CAT_OFF_CNTLO;
  localparam logic [7:0] aHi = `CAT_OFF_CNTHI;
  localparam logic [7:0] aFlag = `CAT_OFF_FLAGS;
  localparam logic [7:0] aMask = `CAT_OFF_MASK;
  localparam logic [7:0] aCh = `CAT_OFF_CH0;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, arrayIrq;
  logic idleMode, timer0Overflow, externalCountInput, extOscDiv8;
  logic rtcOscDiv8, watchdogExpire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] channelIoOut, channelIoOe;
  logic e;
  int nTests, nMismatch;

  cat_counter_array uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idleMode(idleMode), .timer0Overflow(timer0Overflow),
    .externalCountInput(externalCountInput), .extOscDiv8(extOscDiv8),
    .rtcOscDiv8(rtcOscDiv8), .arrayIrq(arrayIrq),
    .channelIoOut(channelIoOut), .channelIoOe(channelIoOe),
    .watchdogExpire(watchdogExpire));

  always #25 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // look mid-cycle: the answer is settled and stands at the next edge
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      check(32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never reassigns psel in this step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    xfer(1'b1, a, d, x, y);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic y;
    xfer(1'b0, a, 32'h0, x, y);
    check(x, exp);
  endtask

  // count source only advances on these one-cycle pulses
  task automatic pulse;
    timer0Overflow <= 1'b1;
    @(posedge sys_clk);
    timer0Overflow <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic setCnt(input logic [15:0] v);
    wr(aLo, {24'h0, v[7:0]});
    wr(aHi, {24'h0, v[15:8]});
  endtask

  // loose bounds: sync delays and the stop write blur the last pulse
  task automatic rate(input logic [2:0] code, input int lo, input int hi);
    logic [31:0] x;
    logic y;
    wr(aMode, 32'h7);
    setCnt(16'h0);
    wr(aMode, {29'h0, code});
    for (int i = 0; i < 120; i++)
    begin
      externalCountInput <= i[2];
      extOscDiv8 <= (code == `CAT_TB_EXTOSC) & i[2];
      rtcOscDiv8 <= (code == `CAT_TB_RTC) & i[2];
      @(posedge sys_clk);
    end
    wr(aMode, 32'h7);
    xfer(1'b0, aLo, 32'h0, x, y);
    check(32'(x >= lo && x <= hi), 32'h1);
  endtask

  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; idleMode = 0; timer0Overflow = 0; externalCountInput = 0;
    extOscDiv8 = 0; rtcOscDiv8 = 0; nTests = 0; nMismatch = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdChk(aMode, 32'h40);
    wr(aCh + 8'h08, 32'h0007_1234);
    rdChk(aCh + 8'h08, 32'h0);
    wr(aMode, 32'h47);
    rdChk(aMode, 32'h40);
    wr(aMode, 32'h0);
    rdChk(aMode, 32'h0);
    $display("test reset and watchdog lock done");
    wr(aMode, 32'h7);
    setCnt(16'h12ff);
    wr(aMode, 32'h2);
    rdChk(aLo, 32'hff);
    pulse;
    rdChk(aHi, 32'h12);
    rdChk(aLo, 32'h0);
    rdChk(aHi, 32'h13);
    wr(aMode, 32'h7);
    pulse;
    rdChk(aLo, 32'h0);
    wr(aMode, 32'ha);
    idleMode <= 1'b1;
    pulse;
    rdChk(aLo, 32'h0);
    wr(aMode, 32'h2);
    pulse;
    rdChk(aLo, 32'h1);
    idleMode <= 1'b0;
    $display("test snapshot, hold and idle done");
    rate(`CAT_TB_DIV12, 9, 11);
    rate(`CAT_TB_DIV4, 29, 32);
    rate(`CAT_TB_EXTCNT, 13, 15);
    rate(`CAT_TB_SYS, 120, 125);
    rate(`CAT_TB_EXTOSC, 13, 15);
    rate(`CAT_TB_RTC, 13, 15);
    // two reads three edges apart while counting every cycle
    wr(aMode, {29'h0, `CAT_TB_SYS});
    xfer(1'b0, aLo, 32'h0, r, e);
    rdChk(aLo, (r + 32'h3) & 32'hff);
    $display("test timebase done");
    wr(aMode, 32'h2);
    wr(aFlag, 32'h1f);
    wr(aMask, 32'h0);
    setCnt(16'hffff);
    pulse;
    rdChk(aFlag, 32'h3);
    check(arrayIrq, 1'b0);
    wr(aMask, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(arrayIrq, 1'b1);
    wr(aFlag, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(arrayIrq, 1'b0);
    rdChk(aFlag, 32'h2);
    wr(aMask, 32'h2);
    repeat (2) @(posedge sys_clk);
    check(arrayIrq, 1'b1);
    wr(aMask, 32'h0);
    for (int l = 0; l < 4; l++)
    begin
      wr(aMode, (32'(l) << 4) | 32'h2);
      setCnt(16'((32'h1 << (8 + l)) - 1));
      wr(aFlag, 32'h1f);
      pulse;
      rdChk(aFlag, 32'h2);
    end
    $display("test flags and irq done");
    wr(aMode, 32'h2);
    for (int c = 0; c < 3; c++)
    begin
      wr(aCh + 8'(4 * c), 32'h0007_0011);
      setCnt(16'h0010);
      wr(aFlag, 32'h1f);
      check(channelIoOe[c], 1'b1);
      pulse;
      rdChk(aFlag, 32'h1 << (2 + c));
      check(channelIoOut[c], 1'b1);
      wr(aCh + 8'(4 * c), 32'h0);
    end
    wr(aCh + 8'h08, 32'h0000_0011);
    wr(aMode, 32'h42);
    setCnt(16'h0010);
    timer0Overflow <= 1'b1;
    @(posedge sys_clk);
    timer0Overflow <= 1'b0;
    @(negedge sys_clk);
    check(watchdogExpire, 1'b1);
    @(negedge sys_clk);
    check(watchdogExpire, 1'b0);
    @(posedge sys_clk);
    xfer(1'b0, 8'h40, 32'h0, r, e);
    check(e, 1'b1);
    check(r, 32'h0);
    $display("test channels and unmapped done");
    conclude;
  end

  // whole run is about eleven hundred cycles; this is far beyond it
  initial
  begin
    #1000000;
    nMismatch++;
    conclude;
  end
endmodule // cat_counter_array_bench
